// ### rtl/inc_pkg.sv
// Constants, register map and state encodings for the interrupt nesting controller.
package inc_pkg;
    localparam int N_SRC = 24;
    localparam int SRC_W = 5;
    localparam int ADDR_W = 8;
    localparam int EV_W = 4;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] OFF_REQ0L = 8'h00;
    localparam logic [7:0] OFF_REQ0H = 8'h04;
    localparam logic [7:0] OFF_REQ1L = 8'h08;
    localparam logic [7:0] OFF_MSK0L = 8'h0C;
    localparam logic [7:0] OFF_MSK0H = 8'h10;
    localparam logic [7:0] OFF_MSK1L = 8'h14;
    localparam logic [7:0] OFF_PRI0L = 8'h18;
    localparam logic [7:0] OFF_PRI0H = 8'h1C;
    localparam logic [7:0] OFF_PRI1L = 8'h20;
    localparam logic [7:0] OFF_PSW = 8'h24;
    localparam logic [7:0] OFF_EVSTAT = 8'h28;
    localparam logic [7:0] OFF_EVMASK = 8'h2C;
    localparam logic [7:0] OFF_STATE = 8'h30;

    // Reset values and status word layout.
    localparam logic [7:0] REQ_RST = 8'h00;
    localparam logic [7:0] MSK_RST = 8'hFF;
    localparam logic [7:0] PRI_RST = 8'hFF;
    localparam logic [7:0] PSW_RST = 8'h02;
    localparam logic [EV_W-1:0] EVM_RST = 4'h0;
    localparam int PSW_IE = 7;
    localparam int PSW_ISP = 1;

    // Vector table addresses.
    localparam logic [15:0] VEC_SW = 16'h003E;
    localparam logic [15:0] VEC_NMI = 16'h0004;
    localparam logic [15:0] VEC_MASK_BASE = 16'h0006;

    // Event status bit positions.
    localparam int EV_SW = 0;
    localparam int EV_NMI = 1;
    localparam int EV_MASK = 2;
    localparam int EV_RET = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_PUSH_PSW = 6'h02,
        S_PUSH_PC = 6'h04,
        S_FETCH = 6'h08,
        S_POP_PC = 6'h10,
        S_POP_PSW = 6'h20
    } inc_state_e;

    typedef enum logic [1:0] {
        K_NONE = 2'h0,
        K_SW = 2'h1,
        K_NMI = 2'h2,
        K_MASK = 2'h3
    } inc_kind_e;
endpackage : inc_pkg

// ### rtl/inc_pick.sv
// Lowest-index set bit finder, used as the default priority order among sources.
module inc_pick #(
    parameter int N = 24,
    parameter int W = 5
) (
    // Candidates
    input wire logic [N-1:0] vec,
    // Result
    output logic found,
    output logic [W-1:0] idx
);
    always_comb begin
        found = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (vec[i]) begin
                found = 1'b1;
                idx = W'(i);
            end
        end
    end
endmodule : inc_pick

// ### rtl/inc_ctrl.sv
// Interrupt acceptance, nesting and context save/restore sequencing with an AXI4-Lite register file.
//
// Behaviour
// - Break instruction always takes a software interrupt.
// - Push status, push PC, clear enable, vector 003E.
// - Break-return restores saved context from stack.
// - Without global enable only non-maskable requests nest.
// - Every acknowledgment clears the global enable.
// - Nest equal or higher priority, refuse lower.
// - Refused requests stay pending until later acceptance.
// - Non-maskable servicing blocks all but break.
// - High-priority servicing nests only high-priority maskables.
// - Low-priority or software servicing nests any maskable.
// - Priority flag 0 high, 1 low, three registers.
// - After hold instructions acceptance waits one instruction.
// - Break is not hold but blocks maskables.
// - Priority flags never affect request flag setting.
// - Maskable pending needs request set, mask clear.
// - Maskable acknowledgment copies source priority into status.
// - Non-maskable acknowledgment sets in-service flag until return.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
module inc_ctrl
    import inc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Instruction boundary from the sequencer
    input wire logic instr_done,
    input wire logic instr_hold,
    input wire logic instr_brk,
    input wire logic instr_break_return_instr,
    input wire logic instr_handler_return_instr,
    input wire logic instr_ei,
    input wire logic instr_di,
    input wire logic [15:0] pc_ret,
    // Interrupt sources
    input wire logic nmi_req,
    input wire logic [N_SRC-1:0] src_req,
    // Stack port
    output logic stk_valid,
    output logic stk_push,
    output logic [15:0] stk_wdata,
    input wire logic [15:0] stk_rdata,
    input wire logic stk_ready,
    // Vector fetch and PC reload
    output logic vec_valid,
    output logic [15:0] vec_addr,
    input wire logic vec_ready,
    output logic pc_load,
    output logic [15:0] pc_load_addr,
    output logic [SRC_W-1:0] ack_src,
    output logic [7:0] program_status_word,
    output logic irq,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef struct packed {
        inc_state_e st;
        inc_kind_e kind;
        logic [7:0] program_status_word;
        logic [N_SRC-1:0] req;
        logic [N_SRC-1:0] mk;
        logic [N_SRC-1:0] pr;
        logic nmi_pend;
        logic nonmaskable_in_service;
        logic sw_serv;
        logic bus_hold;
        logic ret_b;
        logic [15:0] sv_pc;
        logic [15:0] vec;
        logic [15:0] stk_wd;
        logic pc_ld;
        logic [SRC_W-1:0] src;
        logic [EV_W-1:0] stat;
        logic [EV_W-1:0] emsk;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [7:0] wdata;
        logic wen;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } inc_ctl_s;

    localparam inc_ctl_s CTL_RST = '{
        st: S_IDLE, kind: K_NONE, program_status_word: PSW_RST, req: {3{REQ_RST}}, mk: {3{MSK_RST}},
        pr: {3{PRI_RST}}, emsk: EVM_RST, default: '0};

    inc_ctl_s q;
    inc_ctl_s d;
    logic [N_SRC-1:0] pend;
    logic [N_SRC-1:0] hi;
    logic any_found;
    logic hi_found;
    logic [SRC_W-1:0] any_idx;
    logic [SRC_W-1:0] hi_idx;
    logic [SRC_W-1:0] pick;
    logic blocked;
    logic isp_eff;
    logic mask_ok;
    logic take;
    logic [EV_W-1:0] ev;

    ////////////////////////////////////////////////////////////////////////////
    // Source selection: programmable priority first, then lowest index.

    assign pend = q.req & ~q.mk;
    assign hi = pend & ~q.pr;

    inc_pick #(.N(N_SRC), .W(SRC_W)) u_pick_any (
        .vec(pend),
        .found(any_found),
        .idx(any_idx)
    );

    inc_pick #(.N(N_SRC), .W(SRC_W)) u_pick_hi (
        .vec(hi),
        .found(hi_found),
        .idx(hi_idx)
    );

    assign pick = hi_found ? hi_idx : any_idx;
    // A software handler behaves as a low-priority one for nesting purposes.
    assign isp_eff = q.program_status_word[PSW_ISP] | q.sw_serv;
    // Under high-priority service only flag-0 sources qualify; nothing maskable under NMI.
    assign mask_ok = q.program_status_word[PSW_IE] && !q.nonmaskable_in_service && any_found && (isp_eff || hi_found);
    assign blocked = instr_hold | instr_break_return_instr | instr_handler_return_instr | instr_ei | instr_di | q.bus_hold;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        d = q;
        d.pc_ld = 1'b0;
        ev = '0;
        take = 1'b0;
        // Bus read; reading the event status clears it.
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = '0;
            case (s_axi_araddr)
                OFF_REQ0L: d.rdata[7:0] = q.req[7:0];
                OFF_REQ0H: d.rdata[7:0] = q.req[15:8];
                OFF_REQ1L: d.rdata[7:0] = q.req[23:16];
                OFF_MSK0L: d.rdata[7:0] = q.mk[7:0];
                OFF_MSK0H: d.rdata[7:0] = q.mk[15:8];
                OFF_MSK1L: d.rdata[7:0] = q.mk[23:16];
                OFF_PRI0L: d.rdata[7:0] = q.pr[7:0];
                OFF_PRI0H: d.rdata[7:0] = q.pr[15:8];
                OFF_PRI1L: d.rdata[7:0] = q.pr[23:16];
                OFF_PSW: d.rdata[7:0] = q.program_status_word;
                OFF_EVSTAT: begin
                    d.rdata[EV_W-1:0] = q.stat;
                    d.stat = '0;
                end
                OFF_EVMASK: d.rdata[EV_W-1:0] = q.emsk;
                OFF_STATE: d.rdata[7:0] = {q.nonmaskable_in_service, q.sw_serv, q.st};
                default: d.rresp = RESP_SLVERR;
            endcase
        end
        // Bus write; address and data may arrive in either order.
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata[7:0];
            d.wen = s_axi_wstrb[0];
        end
        if (instr_done) begin
            d.bus_hold = 1'b0;
        end
        if (q.aw_got && q.w_got) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            case (q.awaddr)
                OFF_REQ0L: d.req[7:0] = q.wen ? q.wdata : q.req[7:0];
                OFF_REQ0H: d.req[15:8] = q.wen ? q.wdata : q.req[15:8];
                OFF_REQ1L: d.req[23:16] = q.wen ? q.wdata : q.req[23:16];
                OFF_MSK0L: d.mk[7:0] = q.wen ? q.wdata : q.mk[7:0];
                OFF_MSK0H: d.mk[15:8] = q.wen ? q.wdata : q.mk[15:8];
                OFF_MSK1L: d.mk[23:16] = q.wen ? q.wdata : q.mk[23:16];
                OFF_PRI0L: d.pr[7:0] = q.wen ? q.wdata : q.pr[7:0];
                OFF_PRI0H: d.pr[15:8] = q.wen ? q.wdata : q.pr[15:8];
                OFF_PRI1L: d.pr[23:16] = q.wen ? q.wdata : q.pr[23:16];
                OFF_PSW: d.program_status_word = q.wen ? q.wdata : q.program_status_word;
                OFF_EVMASK: d.emsk = q.wen ? q.wdata[EV_W-1:0] : q.emsk;
                OFF_EVSTAT, OFF_STATE: d.bresp = RESP_OKAY;
                default: d.bresp = RESP_SLVERR;
            endcase
            // Touching request, mask, priority or status word defers acceptance a boundary.
            if (q.awaddr <= OFF_PSW) begin
                d.bus_hold = 1'b1;
            end
        end
        // Acceptance decision at an instruction boundary.
        if (q.st == S_IDLE && instr_done) begin
            if (instr_ei) begin
                d.program_status_word[PSW_IE] = 1'b1;
            end
            if (instr_di) begin
                d.program_status_word[PSW_IE] = 1'b0;
            end
            if (instr_brk) begin
                take = 1'b1;
                d.kind = K_SW;
                d.vec = VEC_SW;
                d.sw_serv = 1'b1;
                ev[EV_SW] = 1'b1;
            end else if (instr_break_return_instr || instr_handler_return_instr) begin
                d.ret_b = instr_break_return_instr;
                d.st = S_POP_PC;
            end else if (!blocked && q.nmi_pend && !q.nonmaskable_in_service) begin
                take = 1'b1;
                d.kind = K_NMI;
                d.vec = VEC_NMI;
                d.nonmaskable_in_service = 1'b1;
                d.nmi_pend = 1'b0;
                d.program_status_word[PSW_ISP] = 1'b0;
                ev[EV_NMI] = 1'b1;
            end else if (!blocked && mask_ok) begin
                take = 1'b1;
                d.kind = K_MASK;
                d.src = pick;
                d.vec = VEC_MASK_BASE + 16'({pick, 1'b0});
                d.program_status_word[PSW_ISP] = q.pr[pick];
                d.req[pick] = 1'b0;
                ev[EV_MASK] = 1'b1;
            end
            if (take) begin
                d.st = S_PUSH_PSW;
                d.stk_wd = {8'h00, q.program_status_word};
                d.sv_pc = pc_ret;
                d.program_status_word[PSW_IE] = 1'b0;
            end
        end
        unique case (q.st)
            S_IDLE: d.pc_ld = 1'b0;
            S_PUSH_PSW: begin
                if (stk_ready) begin
                    d.st = S_PUSH_PC;
                    d.stk_wd = q.sv_pc;
                end
            end
            S_PUSH_PC: d.st = stk_ready ? S_FETCH : S_PUSH_PC;
            S_FETCH: d.st = vec_ready ? S_IDLE : S_FETCH;
            S_POP_PC: begin
                if (stk_ready) begin
                    d.sv_pc = stk_rdata;
                    d.st = S_POP_PSW;
                end
            end
            S_POP_PSW: begin
                if (stk_ready) begin
                    d.program_status_word = stk_rdata[7:0];
                    d.pc_ld = 1'b1;
                    d.st = S_IDLE;
                    ev[EV_RET] = 1'b1;
                    // One break level is tracked; a nested break loses the outer mark.
                    if (q.ret_b) begin
                        d.sw_serv = 1'b0;
                    end else begin
                        d.nonmaskable_in_service = 1'b0;
                    end
                end
            end
            default: d.st = S_IDLE;
        endcase
        // Hardware sets win over every clear in the same cycle; priority plays no part.
        d.req = d.req | src_req;
        d.nmi_pend = d.nmi_pend | nmi_req;
        d.stat = d.stat | ev;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= CTL_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign stk_valid = q.st[1] | q.st[2] | q.st[4] | q.st[5];
    assign stk_push = q.st[1] | q.st[2];
    assign stk_wdata = q.stk_wd;
    assign vec_valid = (q.st == S_FETCH);
    assign vec_addr = q.vec;
    assign pc_load = q.pc_ld;
    assign pc_load_addr = q.sv_pc;
    assign ack_src = q.src;
    assign program_status_word = q.program_status_word;
    assign irq = |(q.stat & q.emsk);
    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready = !q.w_got && !q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rvalid = q.rvalid;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_brk_always_taken: assert property (
        q.st == S_IDLE && instr_done && instr_brk |=> q.st == S_PUSH_PSW && q.kind == K_SW)
        else $error("break instruction not acknowledged");
    chk_sw_vector_addr: assert property (
        vec_valid && q.kind == K_SW |-> vec_addr == 16'h003E)
        else $error("software vector address wrong");
    chk_push_order: assert property (
        q.st == S_PUSH_PSW && stk_ready |=> q.st == S_PUSH_PC && stk_wdata == $past(q.sv_pc))
        else $error("PC not pushed after status word");
    chk_ack_clears_ie: assert property (
        q.st == S_IDLE ##1 q.st == S_PUSH_PSW |-> !q.program_status_word[PSW_IE])
        else $error("enable not cleared on acknowledgment");
    chk_no_nest_ie0: assert property (
        q.st == S_IDLE && instr_done && !instr_brk && !instr_break_return_instr && !instr_handler_return_instr && !q.program_status_word[PSW_IE]
        |=> q.st == S_IDLE || q.kind == K_NMI)
        else $error("maskable taken with enable clear");
    chk_nmi_service_blk: assert property (
        q.st == S_IDLE && q.nonmaskable_in_service && instr_done && !instr_brk |=> q.st != S_PUSH_PSW)
        else $error("request nested during non-maskable service");
    chk_hold_defers: assert property (
        q.st == S_IDLE && instr_done && instr_hold && !instr_brk && !instr_break_return_instr && !instr_handler_return_instr |=> q.st == S_IDLE)
        else $error("acknowledged after hold instruction");
    chk_isp_copy: assert property (
        $rose(q.st == S_PUSH_PSW) && q.kind == K_MASK |-> q.program_status_word[PSW_ISP] == $past(q.pr[pick]))
        else $error("source priority not copied into status");
    chk_high_only: assert property (
        $rose(q.st == S_PUSH_PSW) && q.kind == K_MASK && !$past(isp_eff) |-> !$past(q.pr[pick]))
        else $error("low priority nested under high priority");
    chk_pop_order: assert property (
        q.st == S_POP_PC && stk_ready |=> q.st == S_POP_PSW ##[0:300] pc_load)
        else $error("return pop order wrong");
endmodule : inc_ctrl

// ### dv/inc_seq_model.sv
// Behavioural stand-in for the CPU sequencer: a stack memory and a vector fetch port.
module inc_seq_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Stack port
    input wire logic stk_valid,
    input wire logic stk_push,
    input wire logic [15:0] stk_wdata,
    output logic [15:0] stk_rdata,
    output logic stk_ready,
    // Vector fetch
    input wire logic vec_valid,
    output logic vec_ready,
    // Pace: two extra wait cycles on every answer when set
    input wire logic slow
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] mem [0:15];
    logic [3:0] sp;
    logic [1:0] lag;

    // Answers are one-cycle pulses, so a valid that stays up never counts twice.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sp <= 4'h0;
            lag <= 2'h0;
            stk_ready <= 1'b0;
            vec_ready <= 1'b0;
            stk_rdata <= 16'hA5A5;
        end else begin
            stk_ready <= 1'b0;
            vec_ready <= 1'b0;
            // Outside a pop answer the data lines toggle, so stale data can never pass for a pop.
            stk_rdata <= ~stk_rdata;
            if ((stk_valid && !stk_ready) || (vec_valid && !vec_ready)) begin
                lag <= lag + 2'h1;
                if (!slow || lag == 2'h2) begin
                    lag <= 2'h0;
                    if (vec_valid) begin
                        vec_ready <= 1'b1;
                    end else if (stk_push) begin
                        stk_ready <= 1'b1;
                        mem[sp] <= stk_wdata;
                        sp <= sp + 4'h1;
                    end else begin
                        stk_ready <= 1'b1;
                        stk_rdata <= mem[sp - 4'h1];
                        sp <= sp - 4'h1;
                    end
                end
            end
        end
    end
endmodule : inc_seq_model

// ### dv/tb.sv
// Self-checking bench for the interrupt nesting controller with a behavioural sequencer.
module tb
    import inc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [5:0] I_NOP = 6'h00;
    localparam logic [5:0] I_DI = 6'h01;
    localparam logic [5:0] I_EI = 6'h02;
    localparam logic [5:0] I_HANDLER_RETURN_INSTR = 6'h04;
    localparam logic [5:0] I_BREAK_RETURN_INSTR = 6'h08;
    localparam logic [5:0] I_BRK = 6'h10;
    localparam logic [5:0] I_HOLD = 6'h20;
    localparam logic [15:0] NONE = 16'hFFFF;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic slow = 1'b0;
    logic instr_done = 1'b0;
    logic nmi_req = 1'b0;
    logic [5:0] kind = 6'h00;
    logic [15:0] pc_ret = 16'h0000;
    logic [N_SRC-1:0] src_req = '0;
    logic stk_valid, stk_push, stk_ready, vec_valid, vec_ready, pc_load, irq;
    logic [15:0] stk_wdata, stk_rdata, vec_addr, pc_load_addr, last_vec, last_ret;
    logic [SRC_W-1:0] ack_src;
    logic [7:0] program_status_word;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int miscompares = 0, samples_checked = 0, n_vec = 0, n_ret = 0, cycles = 0;

    inc_ctrl u_dut (
        .clk_sys, .rst, .instr_done, .instr_hold(kind[5]), .instr_brk(kind[4]), .instr_break_return_instr(kind[3]),
        .instr_handler_return_instr(kind[2]), .instr_ei(kind[1]), .instr_di(kind[0]), .pc_ret, .nmi_req, .src_req,
        .stk_valid, .stk_push, .stk_wdata, .stk_rdata, .stk_ready, .vec_valid, .vec_addr, .vec_ready,
        .pc_load, .pc_load_addr, .ack_src, .program_status_word, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    inc_seq_model u_mdl (
        .clk_sys, .rst, .stk_valid, .stk_push, .stk_wdata, .stk_rdata, .stk_ready, .vec_valid, .vec_ready, .slow
    );

    always #2 clk_sys = ~clk_sys;

    // Handshakes are seen at the falling edge, where registered outputs have settled.
    always @(negedge clk_sys) begin
        cycles++;
        if (vec_valid && vec_ready) begin
            n_vec++;
            last_vec = vec_addr;
        end
        if (pc_load) begin
            n_ret++;
            last_ret = pc_load_addr;
        end
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t ns: %s", $time, msg);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_hit, w_hit, b_hit;
        logic [1:0] r;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk_sys);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit = s_axi_wvalid && s_axi_wready;
            b_hit = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk_sys);
            if (aw_hit) s_axi_awvalid <= 1'b0;
            if (w_hit) s_axi_wvalid <= 1'b0;
        end while (!b_hit);
        s_axi_bready <= 1'b0;
        // One idle edge keeps a following write from reassigning bready in the same step.
        @(posedge clk_sys);
        chk(r === RESP_OKAY, $sformatf("write %h answer", a));
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hit, r_hit;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk_sys);
            ar_hit = s_axi_arvalid && s_axi_arready;
            r_hit = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_sys);
            if (ar_hit) s_axi_arvalid <= 1'b0;
        end while (!r_hit);
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask : axi_rd

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(d === {24'h00_0000, e} && r === RESP_OKAY, $sformatf("read %h", a));
    endtask : rd_chk

    task automatic raise(input logic nmi, input logic [N_SRC-1:0] s);
        nmi_req <= nmi;
        src_req <= s;
        @(posedge clk_sys);
        nmi_req <= 1'b0;
        src_req <= '0;
    endtask : raise

    // One instruction boundary; exp is the vector expected, or NONE when nothing may be taken.
    task automatic step(input logic [5:0] k, input logic [15:0] pc, input logic [15:0] exp);
        int v0, r0, n;
        v0 = n_vec;
        r0 = n_ret;
        n = 0;
        kind <= k;
        pc_ret <= pc;
        instr_done <= 1'b1;
        @(posedge clk_sys);
        kind <= I_NOP;
        instr_done <= 1'b0;
        while (n_vec == v0 && n_ret == r0 && n < 30) begin
            @(posedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        if (exp === NONE) chk(n_vec == v0, $sformatf("no acceptance at %h", pc));
        else chk(n_vec == v0 + 1 && last_vec === exp, $sformatf("vector at %h", pc));
    endtask : step

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        chk(program_status_word === PSW_RST && irq === 1'b0, "status after reset");
        rd_chk(OFF_MSK1L, MSK_RST);
        rd_chk(OFF_PRI0H, PRI_RST);
        rd_chk(OFF_REQ1L, REQ_RST);
        axi_rd(8'h40, d, r);
        chk(d === 32'h0000_0000 && r === RESP_SLVERR, "unmapped read");
        $display("test reset done");
    endtask : t_reset

    task automatic t_brk();
        axi_wr(OFF_EVMASK, 8'h01);
        axi_wr(OFF_PSW, 8'h82);
        step(I_BRK, 16'h1234, VEC_SW);
        chk(program_status_word === 8'h02 && u_mdl.mem[0] === 16'h0082 && u_mdl.mem[1] === 16'h1234, "break save");
        chk(irq === 1'b1, "event interrupt raised");
        axi_wr(OFF_EVMASK, 8'h00);
        chk(irq === 1'b0, "event interrupt masked");
        rd_chk(OFF_EVSTAT, 8'h01);
        axi_wr(OFF_EVMASK, 8'h01);
        chk(irq === 1'b0, "event status cleared by read");
        step(I_BREAK_RETURN_INSTR, 16'h0010, NONE);
        chk(n_ret == 1 && last_ret === 16'h1234 && program_status_word === 8'h82, "break return");
        $display("test break done");
    endtask : t_brk

    task automatic t_mask();
        raise(1'b0, 24'h00_0008);
        step(I_NOP, 16'h0100, NONE);
        rd_chk(OFF_REQ0L, 8'h08);
        axi_wr(OFF_MSK0L, 8'hF7);
        step(I_NOP, 16'h0102, NONE);
        step(I_BRK, 16'h0104, VEC_SW);
        step(I_DI, 16'h0106, NONE);
        step(I_BREAK_RETURN_INSTR, 16'h0108, NONE);
        step(I_HOLD, 16'h010A, NONE);
        step(I_NOP, 16'h010C, VEC_MASK_BASE + 16'h0006);
        chk(ack_src === 5'h03 && program_status_word === 8'h02, "maskable taken");
        rd_chk(OFF_REQ0L, 8'h00);
        $display("test mask done");
    endtask : t_mask

    task automatic t_nest();
        slow <= 1'b1;
        axi_wr(OFF_PRI0L, 8'hDF);
        axi_wr(OFF_MSK0L, 8'h87);
        raise(1'b0, 24'h00_0070);
        step(I_NOP, 16'h0200, NONE);
        step(I_EI, 16'h0202, NONE);
        step(I_NOP, 16'h0204, VEC_MASK_BASE + 16'h000A);
        chk(ack_src === 5'h05 && program_status_word === 8'h00, "high priority nested");
        step(I_EI, 16'h0206, NONE);
        step(I_NOP, 16'h0208, NONE);
        rd_chk(OFF_REQ0L, 8'h50);
        axi_wr(OFF_PRI0L, 8'h9F);
        step(I_NOP, 16'h020A, NONE);
        step(I_NOP, 16'h020C, VEC_MASK_BASE + 16'h000C);
        chk(ack_src === 5'h06 && program_status_word === 8'h00, "equal priority nested");
        $display("test nesting done");
    endtask : t_nest

    task automatic t_nmi();
        raise(1'b1, 24'h00_0000);
        step(I_NOP, 16'h0300, VEC_NMI);
        step(I_EI, 16'h0302, NONE);
        raise(1'b1, 24'h00_0000);
        step(I_NOP, 16'h0304, NONE);
        step(I_BRK, 16'h0306, VEC_SW);
        step(I_BREAK_RETURN_INSTR, 16'h0308, NONE);
        chk(last_ret === 16'h0306 && program_status_word === 8'h80, "nested break return");
        step(I_HANDLER_RETURN_INSTR, 16'h030A, NONE);
        chk(last_ret === 16'h0300 && program_status_word === 8'h00, "non-maskable return");
        step(I_NOP, 16'h030C, VEC_NMI);
        rd_chk(OFF_EVSTAT, 8'h0F);
        rd_chk(OFF_STATE, 8'h81);
        $display("test non-maskable done");
    endtask : t_nmi

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_brk();
        t_mask();
        t_nest();
        t_nmi();
        test_done();
    end
endmodule : tb
